// ---- hdl/ubrg_divider.v ----
/*
 * reloading down-counter that emits one enable pulse per period.
 * assumes i_tick is a one-cycle enable on the same clock.
 */
`timescale 1ns/100ps
`default_nettype none
module ubrg_divider #(
    parameter WIDTH = 16
) (
    input  wire             i_mclk,    // master clock
    input  wire             i_reset,   // synchronous reset
    input  wire             i_tick,    // input enable
    input  wire [WIDTH-1:0] i_divisor, // division ratio
    output reg              o_pulse    // one pulse per period
);
    reg [WIDTH-1:0] count_reg;

    // --------------------------------------------------------
    // down-counter
    // --------------------------------------------------------
    always @(posedge i_mclk) begin
        if (i_reset) begin
            count_reg <= {WIDTH{1'b0}};
            o_pulse   <= 1'b0;
        end else if (i_divisor == {WIDTH{1'b0}}) begin
            count_reg <= {WIDTH{1'b0}};
            o_pulse   <= 1'b0;
        end else if (i_tick) begin
            if (count_reg <= {{(WIDTH-1){1'b0}}, 1'b1}) begin
                count_reg <= i_divisor;
                o_pulse   <= 1'b1;
            end else begin
                count_reg <= count_reg - {{(WIDTH-1){1'b0}}, 1'b1};
                o_pulse   <= 1'b0;
            end
        end else begin
            o_pulse <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ---- hdl/ubrg_top.v ----
/*
 * baud rate generator with pin direction control for one channel.
 * assumes the serial clock pin meets the external clock limits and that
 * software routes pins through the parallel io controller first.
 */
`include "ubrg_defines.vh"
`timescale 1ns/100ps
`default_nettype none
module ubrg_top #(
    parameter DIV_WIDTH = 16
) (
    input  wire                 i_mclk,                // master clock
    input  wire                 i_reset,               // sync reset, high
    input  wire [7:0]           i_channel_mode,        // mode register image
    input  wire [1:0]           i_clock_source_select, // clock source field
    input  wire                 i_clock_output_enable, // drive clock pin
    input  wire [DIV_WIDTH-1:0] i_clock_divisor,       // divisor register
    input  wire                 i_sck_in,              // serial clock pin in
    input  wire                 i_rx_bit_clk_pin,      // receive data pin
    input  wire                 i_tx_data,             // transmit data
    output reg                  o_sck_out,             // serial clock pin out
    output reg                  o_sck_oe,              // clock pin drive en
    output wire                 o_sck_pio_free,        // pin free for pio
    output reg                  o_tx_pin,              // transmit data pin
    output wire                 o_tx_oe,               // transmit pin enable
    output reg                  o_rx_data,             // synced receive data
    output wire                 o_rx_bit_en,           // receiver bit enable
    output wire                 o_tx_bit_en,           // transmitter bit enable
    output wire                 o_sample_en            // async 16x enable
);
    // ------------------------------------------------------------
    // synchronisers
    // ------------------------------------------------------------
    reg sck_meta_reg;
    reg sck_sync_reg;
    reg sck_last_reg;
    reg rx_meta_reg;
    reg div8_tick_reg;
    reg [2:0] pre_reg;

    always @(posedge i_mclk) begin
        if (i_reset) begin
            sck_meta_reg <= 1'b0;
            sck_sync_reg <= 1'b0;
            sck_last_reg <= 1'b0;
            rx_meta_reg  <= 1'b1;
            o_rx_data    <= 1'b1;
            o_tx_pin     <= 1'b1;
        end else begin
            sck_meta_reg <= i_sck_in;
            sck_sync_reg <= sck_meta_reg;
            sck_last_reg <= sck_sync_reg;
            rx_meta_reg  <= i_rx_bit_clk_pin;
            o_rx_data    <= rx_meta_reg;
            o_tx_pin     <= i_tx_data;
        end
    end

    // ------------------------------------------------------------
    // source selection
    // ------------------------------------------------------------
    wire sync_mode = i_channel_mode[`UBRG_MODE_SYNC_BIT];
    wire ext_src   = i_clock_source_select[`UBRG_SRC_EXT_BIT];
    wire div8_sel  = i_clock_source_select[`UBRG_SRC_DIV8_BIT];
    wire ext_rise  = sck_sync_reg & ~sck_last_reg;

    always @(posedge i_mclk) begin
        if (i_reset) begin
            pre_reg       <= 3'h0;
            div8_tick_reg <= 1'b0;
        end else begin
            pre_reg       <= pre_reg + 3'h1;
            div8_tick_reg <= (pre_reg == `UBRG_PRESCALE_LAST);
        end
    end

    wire src_tick = ext_src ? ext_rise : (div8_sel ? div8_tick_reg : 1'b1);

    // ------------------------------------------------------------
    // dividers
    // ------------------------------------------------------------
    wire cd_pulse;
    wire [DIV_WIDTH-1:0] cd_divisor = (sync_mode && ext_src) ? {DIV_WIDTH{1'b0}} : i_clock_divisor;

    ubrg_divider #(.WIDTH(DIV_WIDTH)) u_cd (
        .i_mclk    (i_mclk),
        .i_reset   (i_reset),
        .i_tick    (src_tick),
        .i_divisor (cd_divisor),
        .o_pulse   (cd_pulse)
    );

    reg [3:0] os_reg;
    reg       async_bit_reg;
    always @(posedge i_mclk) begin
        if (i_reset || sync_mode) begin
            os_reg        <= 4'h0;
            async_bit_reg <= 1'b0;
        end else if (cd_pulse) begin
            os_reg        <= os_reg + 4'h1;
            async_bit_reg <= (os_reg == `UBRG_OVERSAMPLE_LAST);
        end else begin
            async_bit_reg <= 1'b0;
        end
    end

    wire bit_en = sync_mode ? (ext_src ? ext_rise : cd_pulse) : async_bit_reg;
    assign o_rx_bit_en = bit_en;
    assign o_tx_bit_en = bit_en;
    assign o_sample_en = ~sync_mode & cd_pulse;

    // ------------------------------------------------------------
    // pin direction
    // ------------------------------------------------------------
    always @(posedge i_mclk) begin
        if (i_reset) begin
            o_sck_oe  <= 1'b0;
            o_sck_out <= 1'b0;
        end else begin
            o_sck_oe <= ~ext_src & i_clock_output_enable;
            if (cd_pulse)
                o_sck_out <= ~o_sck_out;
        end
    end
    assign o_sck_pio_free = ~ext_src & ~i_clock_output_enable;
    assign o_tx_oe        = 1'b1;
endmodule
`default_nettype wire

// ---- include/ubrg_defines.vh ----
/*
 * constants for the serial port baud rate generator.
 * assumes inclusion by bare name from hdl files; definitions only.
 */
`ifndef UBRG_DEFINES_VH
`define UBRG_DEFINES_VH

`define UBRG_MODE_SYNC_BIT   7
`define UBRG_SRC_EXT_BIT     1
`define UBRG_SRC_DIV8_BIT    0
`define UBRG_PRESCALE        8
`define UBRG_OVERSAMPLE      16
`define UBRG_PRESCALE_LAST   3'h7
`define UBRG_OVERSAMPLE_LAST 4'hF
`define UBRG_DIVISOR_RESET   16'h0000
`define UBRG_MCLK_PERIOD_NS  25

`endif

// ---- verif/ubrg_chk.sv ----
/* port assertions for ubrg_top; bound to every instance of it */
`timescale 1ns/100ps
`default_nettype none
module ubrg_chk #(parameter DIV_WIDTH = 16) (
    input wire logic                 i_mclk, i_reset, i_clock_output_enable, i_sck_in, i_rx_bit_clk_pin, i_tx_data,
    input wire logic [7:0]           i_channel_mode,
    input wire logic [1:0]           i_clock_source_select,
    input wire logic [DIV_WIDTH-1:0] i_clock_divisor,
    input wire logic                 o_sck_oe, o_sck_pio_free, o_tx_pin, o_tx_oe, o_rx_data, o_rx_bit_en,
    input wire logic                 o_tx_bit_en, o_sample_en
);
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_reset);
    wire ext = i_clock_source_select[1];
    wire syn = i_channel_mode[7];
    pin_dir_a: assert property (o_sck_oe == (!$past(ext) && $past(i_clock_output_enable))) else $error("clock pin drive");
    pin_free_a: assert property (o_sck_pio_free == (!ext && !i_clock_output_enable)) else $error("pin free");
    same_clk_a: assert property (o_rx_bit_en == o_tx_bit_en) else $error("rx tx enables differ");
    tx_path_a: assert property (o_tx_oe && o_tx_pin == $past(i_tx_data)) else $error("tx pin");
    rx_path_a: assert property (o_rx_data == $past(i_rx_bit_clk_pin, 2)) else $error("rx data");
    zero_stop_a: assert property ((i_clock_divisor == 0 && !ext) [*8] |-> !o_rx_bit_en && !o_sample_en)
        else $error("enable with zero divisor");
    sync_nosamp_a: assert property (syn [*3] |-> !o_sample_en) else $error("sample enable in sync");
    bit_after_samp_a: assert property (!syn && o_rx_bit_en |-> $past(o_sample_en)) else $error("async bit enable");
    ext_clk_a: assert property ($rose(i_sck_in) && syn && ext |-> ##2 o_rx_bit_en) else $error("ext clock");
    one_pulse_a: assert property (o_rx_bit_en && i_clock_divisor != 1 |=> !o_rx_bit_en) else $error("pulse");
endmodule
bind ubrg_top ubrg_chk #(.DIV_WIDTH(DIV_WIDTH)) u_chk (.*);
`default_nettype wire

// ---- verif/ubrg_ext_dev.sv ----
/* far serial device: clocks the serial pin in frames and sends bits; idle line pulled high */
`timescale 1ns/100ps
`default_nettype none
module ubrg_ext_dev (
    input  wire logic i_run, // frame active
    output var  logic o_sck, // serial clock, still low when idle
    output var  logic o_rxd  // receive line
);
    logic [7:0] pat_reg = 8'hA5;
    initial begin
        o_sck = 1'b0;
        o_rxd = 1'b1;
        forever begin
            #7;
            if (i_run) begin
                #68 o_sck = 1'b1;
                #75 o_sck = 1'b0;
                o_rxd = pat_reg[0];
                pat_reg = {pat_reg[0], pat_reg[7:1]};
            end else o_rxd = 1'b1;
        end
    end
endmodule
`default_nettype wire

// ---- verif/ubrg_top_tb_top.sv ----
/* bench for ubrg_top: pin direction table and bit enable counts per mode; device model on the pins */
`timescale 1ns/100ps
`default_nettype none
module ubrg_top_tb_top;
    logic i_mclk = 1'b0, i_reset = 1'b1, clock_output_enable = 1'b0, tx = 1'b1, run = 1'b0;
    logic [7:0] mode = 8'h00;
    logic [1:0] src = 2'h0;
    logic [15:0] div = 16'h0000;
    wire sck, rxd, sco, oe, free, txp, txoe, rxq, rbe, tbe, se;
    int miscompares = 0, n_tests = 0;
    ubrg_ext_dev i_dev (.i_run(run), .o_sck(sck), .o_rxd(rxd));
    ubrg_top i_dut (.i_mclk(i_mclk), .i_reset(i_reset), .i_channel_mode(mode), .i_clock_source_select(src),
        .i_clock_output_enable(clock_output_enable), .i_clock_divisor(div), .i_sck_in(sck), .i_rx_bit_clk_pin(rxd),
        .i_tx_data(tx), .o_sck_out(sco), .o_sck_oe(oe), .o_sck_pio_free(free), .o_tx_pin(txp), .o_tx_oe(txoe),
        .o_rx_data(rxq), .o_rx_bit_en(rbe), .o_tx_bit_en(tbe), .o_sample_en(se));
    initial forever #12.5 i_mclk = ~i_mclk;
    always @(posedge i_mclk) if (!i_reset) tx <= #1 ~tx;
    task automatic chk(input string nm, input logic [15:0] exp, got);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %0h seen %0h", nm, exp, got);
        end
    endtask
    task automatic run_cfg(input logic [7:0] m, input logic [1:0] s, input logic [15:0] d, input int cyc,
                           input logic [15:0] eb, es, et);
        logic [15:0] nb, ns, nt;
        logic prev;
        nb = 0;
        ns = 0;
        nt = 0;
        @(posedge i_mclk) #1;
        mode = m;
        src = s;
        div = d;
        repeat (300) @(posedge i_mclk);
        @(negedge i_mclk) prev = sco;
        repeat (cyc) @(negedge i_mclk) begin
            nb += rbe;
            ns += se;
            nt += (sco != prev);
            prev = sco;
        end
        chk("bit enables", eb, nb);
        chk("sample enables", es, ns);
        chk("clock pin toggles", et, nt);
    endtask
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        repeat (5) @(negedge i_mclk);
        chk("reset outputs", 16'h0006, {oe, txp, rxq, rbe});
        @(posedge i_mclk) #1 i_reset = 1'b0;
        for (int k = 0; k < 8; k++) begin
            @(posedge i_mclk) #1;
            src = k[1:0];
            clock_output_enable = k[2];
            repeat (2) @(negedge i_mclk);
            chk("clock pin drive", !k[1] & k[2], oe);
            chk("clock pin free", !k[1] & !k[2], free);
        end
        run_cfg(8'h00, 2'h0, 16'h0002, 320, 10, 160, 160);
        run_cfg(8'h00, 2'h1, 16'h0001, 1280, 10, 160, 160);
        run_cfg(8'h80, 2'h1, 16'h0002, 160, 10, 0, 10);
        run_cfg(8'h80, 2'h0, 16'h0003, 60, 20, 0, 20);
        run_cfg(8'h80, 2'h0, 16'h0000, 200, 0, 0, 0);
        run = 1'b1;
        run_cfg(8'h80, 2'h2, 16'h0000, 120, 20, 0, 0);
        run_cfg(8'h00, 2'h2, 16'h0001, 960, 10, 160, 160);
        final_report();
    end
endmodule
`default_nettype wire
